// ### core/scfg_top.sv
// System configuration register with its clock, reset pin, power and chip select controls
//
// Notes on behaviour
// - 16-bit register, stack size in bits 15:13
// - Reset value zero except the strap bits sampled from pins
// - ROM, byte-high, write bits loaded from straps
// - Writes ignored after end-of-init instruction
// - Extension peripherals disabled while enable bit 0
// - Extension peripherals enabled while enable bit 1
// - Reset pin input only when bidir bit 0
// - Bidir bit 1: pin low 1024 phases
// - Watchdog on, PLL bypassed: dead crystal switches to PLL
// - Watchdog off, PLL bypassed: crystal clock, PLL turned off
// - Config 0: power-down entry only with NMI low
// - Config 0: power-down left only by reset
// - Config 1: entry needs all enabled interrupts inactive
// - Config 1: any enabled interrupt exits power-down
// - Config 0: chip selects one cycle (two phases) after ALE rise
// - Config 1: chip selects update with ALE rise
`timescale 1ns/1ps
module scfg_top #(
    parameter int NUM_CS = 5,
    parameter int NUM_FIRQ = 4
) (
    input wire logic clk_sys,
    input wire logic srst,
    input wire scfg_pkg::scfg_req_type reg_req,
    output logic [15:0] reg_rdata,
    input wire logic end_of_init_instruction,
    input wire logic [15:0] config_port_pins,
    input wire logic external_access_pin,
    input wire logic internal_reset_req,
    input wire logic reset_input_pin_i,
    output logic reset_input_pin_o,
    output logic reset_input_pin_oe,
    input wire logic crystal_input,
    input wire logic pll_bypass,
    output logic pll_enable,
    output logic clk_select_pll,
    input wire logic powerdown_instruction,
    input wire logic nmi_pin_n,
    input wire logic [NUM_FIRQ-1:0] fast_ext_irq_pins,
    input wire logic [NUM_FIRQ-1:0] fast_irq_enable,
    input wire logic [NUM_FIRQ-1:0] fast_irq_active_high,
    output logic powerdown,
    output logic ext_periph_enable,
    output logic periph_sharing,
    input wire logic ale,
    input wire logic [NUM_CS-1:0] cs_next,
    output logic [NUM_CS-1:0] chip_select_outputs
);
    // Two-stage synchronisers for pin inputs
    logic [15:0] strap_s1_q;
    logic [15:0] strap_s2_q;
    logic ea_s1_q;
    logic ea_s2_q;
    logic rpin_s1_q;
    logic rpin_s2_q;
    logic xtal_s1_q;
    logic xtal_s2_q;
    logic xtal_s3_q;
    logic nmi_s1_q;
    logic nmi_s2_q;
    logic [NUM_FIRQ-1:0] firq_s1_q;
    logic [NUM_FIRQ-1:0] firq_s2_q;

    always_ff @(posedge clk_sys)
    begin
        strap_s1_q <= config_port_pins;
        strap_s2_q <= strap_s1_q;
        ea_s1_q <= external_access_pin;
        ea_s2_q <= ea_s1_q;
        rpin_s1_q <= reset_input_pin_i;
        rpin_s2_q <= rpin_s1_q;
        xtal_s1_q <= crystal_input;
        xtal_s2_q <= xtal_s1_q;
        xtal_s3_q <= xtal_s2_q;
        nmi_s1_q <= nmi_pin_n;
        nmi_s2_q <= nmi_s1_q;
        firq_s1_q <= fast_ext_irq_pins;
        firq_s2_q <= firq_s1_q;
    end

    // Configuration register and freeze
    scfg_pkg::scfg_fields_type cfg_q;
    scfg_pkg::scfg_fields_type cfg_d;
    logic frozen_q;
    logic strap_pending_q;
    logic [15:0] status_word;
    logic [15:0] rdata_d;
    wire sel_cfg = reg_req.addr == scfg_pkg::SYSCFG_ADDR;
    wire sel_stat = reg_req.addr == scfg_pkg::STATUS_ADDR;
    wire cfg_write = reg_req.wr && sel_cfg && !frozen_q;

    always_comb
    begin
        cfg_d = cfg_q;
        if (cfg_write)
        begin
            cfg_d = scfg_pkg::scfg_fields_type'(reg_req.wdata);
        end
        if (strap_pending_q)
        begin
            cfg_d.internal_rom_enable = ea_s2_q;
            cfg_d.byte_high_disable = strap_s2_q[scfg_pkg::STRAP_BYTE_HIGH_DISABLE_POS];
            cfg_d.write_strobe_config = !strap_s2_q[scfg_pkg::STRAP_WRITE_STROBE_CONFIG_POS];
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (srst)
        begin
            cfg_q <= scfg_pkg::scfg_fields_type'(scfg_pkg::SYSCFG_RESET);
            frozen_q <= 1'b0;
            strap_pending_q <= 1'b1;
        end
        else
        begin
            cfg_q <= cfg_d;
            frozen_q <= frozen_q || end_of_init_instruction;
            strap_pending_q <= 1'b0;
        end
    end

    // Reset pin driver
    scfg_pkg::scfg_rpin_type rpin_state_q;
    logic [scfg_pkg::RST_CNT_W-1:0] rpin_cnt_q;
    localparam logic [scfg_pkg::RST_CNT_W-1:0] RPIN_LAST =
        scfg_pkg::RST_CNT_W'(scfg_pkg::RST_DRIVE_CYCLES - 1);
    wire rpin_start = internal_reset_req && cfg_q.bidir_reset_enable;

    always_ff @(posedge clk_sys)
    begin
        if (srst)
        begin
            rpin_state_q <= scfg_pkg::RP_IDLE;
            rpin_cnt_q <= '0;
        end
        else
        begin
            unique case (rpin_state_q)
                scfg_pkg::RP_IDLE:
                begin
                    rpin_cnt_q <= '0;
                    if (rpin_start)
                    begin
                        rpin_state_q <= scfg_pkg::RP_DRIVE;
                    end
                end
                scfg_pkg::RP_DRIVE:
                begin
                    rpin_cnt_q <= rpin_cnt_q + 1'b1;
                    if (rpin_cnt_q == RPIN_LAST)
                    begin
                        rpin_state_q <= scfg_pkg::RP_IDLE;
                    end
                end
            endcase
        end
    end

    // Oscillator monitor
    logic [scfg_pkg::OSC_CNT_W-1:0] osc_cnt_q;
    logic osc_fail_q;
    localparam logic [scfg_pkg::OSC_CNT_W-1:0] OSC_LIMIT =
        scfg_pkg::OSC_CNT_W'(scfg_pkg::OSC_IDLE_CYCLES);
    wire xtal_edge = xtal_s2_q != xtal_s3_q;
    wire osc_watch = pll_bypass && !cfg_q.osc_watchdog_disable;
    wire osc_dead = osc_cnt_q == OSC_LIMIT;

    always_ff @(posedge clk_sys)
    begin
        if (srst || xtal_edge || !osc_watch)
        begin
            osc_cnt_q <= '0;
        end
        else if (!osc_dead)
        begin
            osc_cnt_q <= osc_cnt_q + 1'b1;
        end
        if (srst)
        begin
            osc_fail_q <= 1'b0;
        end
        else if (osc_watch && osc_dead)
        begin
            osc_fail_q <= 1'b1;
        end
    end

    // Power-down control
    scfg_pkg::scfg_pd_type pd_state_q;
    wire [NUM_FIRQ-1:0] firq_active =
        fast_irq_enable & ~(firq_s2_q ^ fast_irq_active_high);
    wire any_firq = |firq_active;
    wire pd_allowed = cfg_q.powerdown_config ? !any_firq : !nmi_s2_q;

    always_ff @(posedge clk_sys)
    begin
        if (srst)
        begin
            pd_state_q <= scfg_pkg::PD_RUN;
        end
        else
        begin
            unique case (pd_state_q)
                scfg_pkg::PD_RUN:
                begin
                    if (powerdown_instruction && pd_allowed)
                    begin
                        pd_state_q <= scfg_pkg::PD_DOWN;
                    end
                end
                scfg_pkg::PD_DOWN:
                begin
                    if (cfg_q.powerdown_config && any_firq)
                    begin
                        pd_state_q <= scfg_pkg::PD_RUN;
                    end
                end
            endcase
        end
    end

    // Chip select timing
    logic ale_q;
    logic [NUM_CS-1:0] cs_hold_q;
    logic cs_late_q;
    wire ale_rise = ale && !ale_q;

    always_ff @(posedge clk_sys)
    begin
        if (srst)
        begin
            ale_q <= 1'b0;
            cs_hold_q <= '0;
            cs_late_q <= 1'b0;
            chip_select_outputs <= '0;
        end
        else
        begin
            ale_q <= ale;
            cs_late_q <= ale_rise && !cfg_q.chip_select_config;
            if (ale_rise)
            begin
                cs_hold_q <= cs_next;
            end
            if (ale_rise && cfg_q.chip_select_config)
            begin
                chip_select_outputs <= cs_next;
            end
            else if (cs_late_q)
            begin
                chip_select_outputs <= cs_hold_q;
            end
        end
    end

    // Register read port and flopped outputs
    assign status_word = {12'h000, rpin_state_q == scfg_pkg::RP_DRIVE, clk_select_pll,
        pd_state_q == scfg_pkg::PD_DOWN, frozen_q};
    assign rdata_d = !reg_req.rd ? 16'h0000 : sel_cfg ? 16'(cfg_q) :
        sel_stat ? status_word : 16'h0000;

    always_ff @(posedge clk_sys)
    begin
        if (srst)
        begin
            reg_rdata <= 16'h0000;
            reset_input_pin_o <= 1'b0;
            reset_input_pin_oe <= 1'b0;
            pll_enable <= 1'b1;
            clk_select_pll <= 1'b0;
            powerdown <= 1'b0;
            ext_periph_enable <= 1'b0;
            periph_sharing <= 1'b0;
        end
        else
        begin
            reg_rdata <= rdata_d;
            reset_input_pin_o <= 1'b0;
            reset_input_pin_oe <= rpin_state_q == scfg_pkg::RP_DRIVE;
            pll_enable <= !(pll_bypass && cfg_q.osc_watchdog_disable);
            clk_select_pll <= osc_fail_q && !cfg_q.osc_watchdog_disable;
            powerdown <= pd_state_q == scfg_pkg::PD_DOWN;
            ext_periph_enable <= cfg_q.ext_periph_enable;
            periph_sharing <= cfg_q.periph_sharing;
        end
    end

    // Helper: length of the last reset pin drive
    logic [scfg_pkg::RST_CNT_W:0] oe_run_q;
    always_ff @(posedge clk_sys)
    begin
        if (srst || !reset_input_pin_oe)
        begin
            oe_run_q <= '0;
        end
        else
        begin
            oe_run_q <= oe_run_q + 1'b1;
        end
    end

    sequence cs_latched_s;
        ale_rise && !cfg_q.chip_select_config ##1 !ale_rise;
    endsequence

    sequence pd_enter_s;
        powerdown_instruction && pd_state_q == scfg_pkg::PD_RUN && !cfg_q.powerdown_config
            && nmi_s2_q;
    endsequence

    strap_load_a: assert property (@(posedge clk_sys)
        $fell(srst) |=> cfg_q.internal_rom_enable == $past(ea_s2_q))
        else $error("strap not loaded into rom enable");

    frozen_write_a: assert property (@(posedge clk_sys) disable iff (srst)
        frozen_q && reg_req.wr && sel_cfg |=> $stable(cfg_q))
        else $error("write changed frozen register");

    ext_periph_enable_out_a: assert property (@(posedge clk_sys) disable iff (srst)
        !cfg_q.ext_periph_enable ##1 !cfg_q.ext_periph_enable |-> !ext_periph_enable)
        else $error("peripherals enabled while bit clear");

    rst_pin_idle_a: assert property (@(posedge clk_sys) disable iff (srst)
        internal_reset_req && !cfg_q.bidir_reset_enable && !reset_input_pin_oe
            && rpin_state_q == scfg_pkg::RP_IDLE |=> ##1 !reset_input_pin_oe)
        else $error("reset pin driven while input only");

    rst_pin_len_a: assert property (@(posedge clk_sys) disable iff (srst)
        $fell(reset_input_pin_oe) |-> oe_run_q == scfg_pkg::RST_DRIVE_CYCLES)
        else $error("reset pin drive length wrong");

    owd_switch_a: assert property (@(posedge clk_sys) disable iff (srst)
        osc_watch && osc_dead |=> ##1 clk_select_pll || cfg_q.osc_watchdog_disable)
        else $error("dead crystal not replaced by pll");

    owd_off_a: assert property (@(posedge clk_sys) disable iff (srst)
        pll_bypass && cfg_q.osc_watchdog_disable |=> !pll_enable && !clk_select_pll)
        else $error("pll left on with watchdog disabled");

    pd_nmi_a: assert property (@(posedge clk_sys) disable iff (srst)
        pd_enter_s |=> pd_state_q == scfg_pkg::PD_RUN)
        else $error("power-down entered with nmi high");

    pd_stay_a: assert property (@(posedge clk_sys) disable iff (srst)
        pd_state_q == scfg_pkg::PD_DOWN && !cfg_q.powerdown_config
            |=> pd_state_q == scfg_pkg::PD_DOWN)
        else $error("power-down left without reset");

    pd_irq_a: assert property (@(posedge clk_sys) disable iff (srst)
        powerdown_instruction && cfg_q.powerdown_config && any_firq
            && pd_state_q == scfg_pkg::PD_RUN |=> ##1 !powerdown)
        else $error("power-down entered with interrupt active");

    pd_exit_a: assert property (@(posedge clk_sys) disable iff (srst)
        pd_state_q == scfg_pkg::PD_DOWN && cfg_q.powerdown_config && any_firq
            |=> ##1 !powerdown)
        else $error("interrupt did not end power-down");

    cs_latched_a: assert property (@(posedge clk_sys) disable iff (srst)
        cs_latched_s |=> chip_select_outputs == $past(cs_next, 2))
        else $error("latched chip select timing wrong");

    cs_unlatched_a: assert property (@(posedge clk_sys) disable iff (srst)
        ale_rise && cfg_q.chip_select_config |=> chip_select_outputs == $past(cs_next))
        else $error("unlatched chip select timing wrong");
endmodule : scfg_top

// ### core/scfg_pkg.sv
// Constants and types for the system configuration register block
package scfg_pkg;
    // Register map
    localparam logic [15:0] SYSCFG_ADDR = 16'hFF12;
    localparam logic [15:0] STATUS_ADDR = 16'hFF14;
    localparam logic [15:0] SYSCFG_RESET = 16'h0000;
    // Strap positions on the configuration port
    localparam int STRAP_BYTE_HIGH_DISABLE_POS = 7;
    localparam int STRAP_WRITE_STROBE_CONFIG_POS = 8;
    // Status register bit positions
    localparam int STAT_FROZEN_POS = 0;
    localparam int STAT_PDOWN_POS = 1;
    localparam int STAT_PLLCLK_POS = 2;
    localparam int STAT_RSTDRV_POS = 3;
    // Timing
    localparam int CLK_PERIOD_NS = 20;
    localparam int RST_DRIVE_PHASES = 1024;
    localparam int PHASES_PER_CYCLE = 2;
    localparam int RST_DRIVE_CYCLES = RST_DRIVE_PHASES / PHASES_PER_CYCLE;
    localparam int OSC_IDLE_NS = 1000;
    localparam int OSC_IDLE_CYCLES = (OSC_IDLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CS_LATCH_PHASES = 1;
    localparam int CS_LATCH_CYCLES =
        (CS_LATCH_PHASES + PHASES_PER_CYCLE - 1) / PHASES_PER_CYCLE;
    localparam int RST_CNT_W = 10;
    localparam int OSC_CNT_W = 7;

    typedef struct packed {
        logic [2:0] stack_size_field;
        logic rom_segment_map;
        logic segmentation_disable;
        logic internal_rom_enable;
        logic byte_high_disable;
        logic clock_output_enable;
        logic write_strobe_config;
        logic chip_select_config;
        logic powerdown_config;
        logic osc_watchdog_disable;
        logic bidir_reset_enable;
        logic ext_periph_enable;
        logic visible_mode;
        logic periph_sharing;
    } scfg_fields_type;

    typedef struct packed {
        logic [15:0] addr;
        logic [15:0] wdata;
        logic wr;
        logic rd;
    } scfg_req_type;

    typedef enum logic {RP_IDLE, RP_DRIVE} scfg_rpin_type;
    typedef enum logic {PD_RUN, PD_DOWN} scfg_pd_type;
endpackage : scfg_pkg

// ### test/system_config_register_test.sv
// Self-checking bench for the system configuration register block
`timescale 1ns/1ps
`define CHK(a, e) begin total_checks++; if ((a) !== (e)) begin error_cnt++; \
    $display("MISMATCH t=%0t got %h exp %h", $time, a, e); end end
`define WAITV(c, lim) begin k = 0; while ((c) !== 1'b1 && k < lim) begin @(posedge clk_sys); \
    #1; k++; end if ((c) !== 1'b1) begin error_cnt++; \
    $display("MISMATCH t=%0t wait ran out", $time); \
    end_sim(); end end
module system_config_register_test;
    localparam logic [15:0] CFG_A = scfg_pkg::SYSCFG_ADDR;
    localparam logic [15:0] STAT_A = scfg_pkg::STATUS_ADDR;
    logic clk_sys = 1'b0;
    logic srst = 1'b1;
    scfg_pkg::scfg_req_type reg_req = '0;
    logic [15:0] reg_rdata;
    logic end_of_init_instruction = 1'b0;
    logic [15:0] config_port_pins = 16'h0080;
    logic external_access_pin = 1'b1;
    logic internal_reset_req = 1'b0;
    logic crystal_input = 1'b0;
    logic osc_run = 1'b1;
    logic pll_bypass = 1'b1;
    logic powerdown_instruction = 1'b0;
    logic nmi_pin_n = 1'b1;
    logic [3:0] fast_ext_irq_pins = 4'h0;
    logic [3:0] fast_irq_enable = 4'h0;
    logic [3:0] fast_irq_active_high = 4'h0;
    logic ale = 1'b0;
    logic [4:0] cs_next = 5'h00;
    logic reset_input_pin_o, reset_input_pin_oe, pll_enable, clk_select_pll, powerdown;
    logic ext_periph_enable, periph_sharing, seen;
    logic [4:0] chip_select_outputs, v, old;
    wire logic rst_pin_lvl;
    scfg_pkg::scfg_fields_type cfg;
    logic [15:0] pats [4] = '{16'hFFFF, 16'h0000, 16'hA000, 16'h5555};
    int error_cnt = 0;
    int total_checks = 0;
    int k, n;

    // Pulled-up pin, low only while the block drives it
    assign rst_pin_lvl = reset_input_pin_oe ? reset_input_pin_o : 1'b1;

    always #10 clk_sys = ~clk_sys;

    always @(posedge clk_sys)
        if (osc_run) crystal_input <= ~crystal_input;

    scfg_top uut (
        .clk_sys(clk_sys), .srst(srst), .reg_req(reg_req), .reg_rdata(reg_rdata),
        .end_of_init_instruction(end_of_init_instruction),
        .config_port_pins(config_port_pins), .external_access_pin(external_access_pin),
        .internal_reset_req(internal_reset_req), .reset_input_pin_i(rst_pin_lvl),
        .reset_input_pin_o(reset_input_pin_o), .reset_input_pin_oe(reset_input_pin_oe),
        .crystal_input(crystal_input), .pll_bypass(pll_bypass), .pll_enable(pll_enable),
        .clk_select_pll(clk_select_pll), .powerdown_instruction(powerdown_instruction),
        .nmi_pin_n(nmi_pin_n), .fast_ext_irq_pins(fast_ext_irq_pins),
        .fast_irq_enable(fast_irq_enable), .fast_irq_active_high(fast_irq_active_high),
        .powerdown(powerdown), .ext_periph_enable(ext_periph_enable),
        .periph_sharing(periph_sharing), .ale(ale), .cs_next(cs_next),
        .chip_select_outputs(chip_select_outputs)
    );

    task automatic end_sim;
        $display("checks %0d mismatches %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0)
        begin
            $display("Finished cleanly");
        end
        else
        begin
            $display("Finished with errors");
        end
        $finish;
    endtask : end_sim

    task automatic do_reset;
        @(posedge clk_sys);
        srst <= 1'b1;
        repeat (5) @(posedge clk_sys);
        srst <= 1'b0;
        repeat (2) @(posedge clk_sys);
        #1;
    endtask : do_reset

    task automatic wr(input logic [15:0] a, input logic [15:0] d);
        @(posedge clk_sys);
        reg_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge clk_sys);
        reg_req.wr <= 1'b0;
    endtask : wr

    task automatic rd_chk(input logic [15:0] a, input logic [15:0] e);
        @(posedge clk_sys);
        reg_req <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
        @(posedge clk_sys);
        reg_req.rd <= 1'b0;
        #1;
        `CHK(reg_rdata, e)
    endtask : rd_chk

    // Outputs follow the register from the second edge after the write
    task automatic set_cfg(input scfg_pkg::scfg_fields_type c);
        wr(CFG_A, c);
        @(posedge clk_sys);
        #1;
    endtask : set_cfg

    task automatic pd_pulse;
        @(posedge clk_sys);
        powerdown_instruction <= 1'b1;
        @(posedge clk_sys);
        powerdown_instruction <= 1'b0;
        #1;
    endtask : pd_pulse

    initial
    begin
        do_reset();
        rd_chk(CFG_A, 16'h0680);
        `CHK(ext_periph_enable, 1'b0)
        for (int i = 0; i < 4; i++)
        begin
            wr(CFG_A, pats[i]);
            rd_chk(CFG_A, pats[i]);
            `CHK(ext_periph_enable, pats[i][2])
            `CHK(periph_sharing, pats[i][0])
        end
        rd_chk(16'hFF16, 16'h0000);
        $display("test register access done");
        old = 5'h00;
        for (int u = 0; u < 2; u++)
        begin
            cfg = '0;
            cfg.chip_select_config = u[0];
            set_cfg(cfg);
            v = u[0] ? 5'h0A : 5'h15;
            @(posedge clk_sys);
            cs_next <= v;
            ale <= 1'b1;
            @(posedge clk_sys);
            ale <= 1'b0;
            #1;
            `CHK(chip_select_outputs, u[0] ? v : old)
            @(posedge clk_sys);
            #1;
            `CHK(chip_select_outputs, v)
            old = v;
        end
        $display("test chip select done");
        cfg = '0;
        cfg.bidir_reset_enable = 1'b1;
        set_cfg(cfg);
        @(posedge clk_sys);
        internal_reset_req <= 1'b1;
        @(posedge clk_sys);
        internal_reset_req <= 1'b0;
        #1;
        `WAITV(reset_input_pin_oe, 4)
        `CHK(rst_pin_lvl, 1'b0)
        n = 0;
        while (reset_input_pin_oe && n < 600)
        begin
            n++;
            @(posedge clk_sys);
            #1;
        end
        `CHK(n, 512)
        cfg = '0;
        set_cfg(cfg);
        @(posedge clk_sys);
        internal_reset_req <= 1'b1;
        @(posedge clk_sys);
        internal_reset_req <= 1'b0;
        seen = 1'b0;
        repeat (20)
        begin
            @(posedge clk_sys);
            #1;
            seen = seen | reset_input_pin_oe;
        end
        `CHK(seen, 1'b0)
        $display("test reset pin done");
        cfg.osc_watchdog_disable = 1'b1;
        set_cfg(cfg);
        osc_run <= 1'b0;
        repeat (80) @(posedge clk_sys);
        #1;
        `CHK(pll_enable, 1'b0)
        `CHK(clk_select_pll, 1'b0)
        cfg = '0;
        set_cfg(cfg);
        `WAITV(clk_select_pll, 100)
        `CHK(pll_enable, 1'b1)
        osc_run <= 1'b1;
        $display("test oscillator done");
        cfg.powerdown_config = 1'b1;
        set_cfg(cfg);
        fast_irq_enable <= 4'h3;
        fast_irq_active_high <= 4'h1;
        fast_ext_irq_pins <= 4'b0100;
        repeat (4) @(posedge clk_sys);
        pd_pulse();
        repeat (10) @(posedge clk_sys);
        #1;
        `CHK(powerdown, 1'b0)
        fast_ext_irq_pins <= 4'b0110;
        repeat (4) @(posedge clk_sys);
        pd_pulse();
        `WAITV(powerdown, 6)
        fast_ext_irq_pins <= 4'b0111;
        `WAITV(!powerdown, 8)
        fast_ext_irq_pins <= 4'b0110;
        cfg = '0;
        set_cfg(cfg);
        repeat (4) @(posedge clk_sys);
        pd_pulse();
        repeat (10) @(posedge clk_sys);
        #1;
        `CHK(powerdown, 1'b0)
        nmi_pin_n <= 1'b0;
        repeat (4) @(posedge clk_sys);
        pd_pulse();
        `WAITV(powerdown, 6)
        nmi_pin_n <= 1'b1;
        fast_ext_irq_pins <= 4'b0111;
        repeat (20) @(posedge clk_sys);
        #1;
        `CHK(powerdown, 1'b1)
        config_port_pins <= 16'h0100;
        external_access_pin <= 1'b0;
        do_reset();
        `CHK(powerdown, 1'b0)
        rd_chk(CFG_A, 16'h0000);
        $display("test power-down done");
        wr(CFG_A, 16'h1234);
        @(posedge clk_sys);
        end_of_init_instruction <= 1'b1;
        @(posedge clk_sys);
        end_of_init_instruction <= 1'b0;
        wr(CFG_A, 16'hFFFF);
        rd_chk(CFG_A, 16'h1234);
        rd_chk(STAT_A, 16'h0001);
        $display("test freeze done");
        end_sim();
    end
endmodule : system_config_register_test
